// ### verilog/isp_device.sv
// How it works
// R1 - enable bit swaps pins GPIO versus bus
// R2 - lines only pulled low or released
// R3 - runs at 1 MHz, 400 kHz, 100 kHz
// R4 - eight-bit groups, most significant bit first
// R5 - change data at low, sample at high
// R6 - master opens every transaction with start
// R7 - data rising while clock high is stop
// R8 - watch addresses, answer own address
// R9 - receiver pulls data low in ninth clock
// R10 - write: start, address, register, data, stop
// R11 - device acknowledges all three write bytes
// R12 - read: write pointer, restart, read address
// R13 - master ends read with nack, stop
// R14 - current limit in bits 3..0 only
// R15 - mode register: select bit, two modes
// R16 - event clears by one only when source gone
// R17 - status bits show live condition
// R18 - foreign address: release data until start
// R19 - undefined reads zero, reserved writes ignored
//
// Register access over Avalon-MM was chosen for this implementation.
`include "isp_defines.svh"
module isp_device import isp_pkg::*; #(
   parameter logic [7:0] PART_ID = 8'h5a,   // arbitrary value
   parameter logic [7:0] REV_ID = 8'h11,    // arbitrary value
   parameter logic [7:0] CUST_ID = 8'h22,   // arbitrary value
   parameter logic [7:0] CFG_REV = 8'h33    // arbitrary value
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // serial bus
   isp_if.dev bus,
   // pin sharing
   input wire logic serial_en,
   input wire logic [1:0] gpio_out,
   input wire logic [1:0] gpio_oe,
   output logic [1:0] gpio_in,
   // monitored conditions
   input wire logic [`ISP_TH_W-1:0] thermal,
   input wire logic [`ISP_BF_W-1:0] buck_fault,
   input wire logic [`ISP_PL_W-1:0] pin_level,
   // controls and interrupt
   output logic irq,
   output logic [3:0] buck_current_limit_field,
   output logic output_setting_select,
   output logic [1:0] setting_one_operating_mode,
   output logic [1:0] setting_two_operating_mode,
   output logic [7:0] voltage_a,
   output logic [7:0] voltage_b
);
   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   isp_dev_st_t st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic ack_q;
   logic oe_q;
   logic rd_q;
   logic nack_q;
   logic [1:0] bidx_q;
   logic [7:0] ptr_q;
   logic [7:0] rdat;
   logic wr_stb;
   logic [7:0] rw_q [0:(1 << `ISP_MAP_AW)-1];
   logic [`ISP_EV_W-1:0] src;
   logic [`ISP_EV_W-1:0] src_q;
   logic [`ISP_EV_W-1:0] ev_q;
   logic [`ISP_EV_W-1:0] clr;
   logic [`ISP_EV_W-1:0] msk;
   logic [7:0] lv_msk;
   logic irq_q;

   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         `ISP_R_TH_MSK: wmask = `ISP_WM_TH;
         `ISP_R_BF_MSK: wmask = `ISP_WM_BF;
         `ISP_R_PL_MSK: wmask = `ISP_WM_PL;
         `ISP_R_LV_MSK: wmask = `ISP_WM_LV;
         `ISP_R_FLT: wmask = `ISP_WM_FLT;
         `ISP_R_OSC: wmask = `ISP_WM_OSC;
         `ISP_R_P0_FN, `ISP_R_P1_FN, `ISP_R_P2_FN: wmask = `ISP_WM_FN;
         `ISP_R_P0_IN, `ISP_R_P1_IN, `ISP_R_P2_IN: wmask = `ISP_WM_FULL;
         `ISP_R_BK_VMAX, `ISP_R_BK_VA, `ISP_R_BK_VB: wmask = `ISP_WM_FULL;
         `ISP_R_BK_EN, `ISP_R_BK_RAMP: wmask = `ISP_WM_BK7;
         // R14 limit field only
         `ISP_R_BK_ILIM: wmask = `ISP_WM_ILIM;
         // R15 select and modes
         `ISP_R_BK_MODE: wmask = `ISP_WM_MODE;
         // R19 nothing writable
         default: wmask = 8'h00;
      endcase
   endfunction

   // R3 oversampling at system clock covers all bus rates
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
      end else begin
         scl_s <= {scl_s[1:0], bus.scl};
         sda_s <= {sda_s[1:0], bus.sda};
      end
   end

   assign scl_rise = scl_s[1] & ~scl_s[2];
   assign scl_fall = ~scl_s[1] & scl_s[2];
   // R6 falling data while clock high
   assign start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   // R7 rising data while clock high
   assign stop = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

   // R11 data byte taken at its acknowledge
   assign wr_stb = serial_en & ~start & ~stop & (st_q == DS_RX) & scl_fall & ~ack_q &
      (bit_q == `ISP_BITS) & (bidx_q == 2'h2) & ~rd_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= DS_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
         rd_q <= 1'b0;
         nack_q <= 1'b0;
         bidx_q <= 2'h0;
         ptr_q <= 8'h00;
      end else if (!serial_en || stop) begin
         st_q <= DS_IDLE;
         oe_q <= 1'b0;
         ack_q <= 1'b0;
      end else if (start) begin
         // R18 a new start ends any ignoring
         st_q <= DS_RX;
         bit_q <= 4'h0;
         bidx_q <= 2'h0;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         case (st_q)
            DS_RX: begin
               if (scl_rise && !ack_q) begin
                  // R4 R5 shift in on high, msb first
                  sh_q <= {sh_q[6:0], sda_s[1]};
                  bit_q <= bit_q + 4'h1;
               end else if (scl_fall && ack_q) begin
                  ack_q <= 1'b0;
                  oe_q <= 1'b0;
                  bit_q <= 4'h0;
                  if (bidx_q != 2'h2) begin
                     bidx_q <= bidx_q + 2'h1;
                  end
                  // R12 read direction turns to sending
                  if (rd_q && bidx_q == 2'h0) begin
                     st_q <= DS_TX;
                     sh_q <= {rdat[6:0], 1'b0};
                     oe_q <= ~rdat[7];
                  end
               end else if (scl_fall && bit_q == `ISP_BITS) begin
                  // R9 R11 pull data low for ninth clock
                  ack_q <= 1'b1;
                  oe_q <= 1'b1;
                  if (bidx_q == 2'h0) begin
                     rd_q <= sh_q[0];
                     // R8 R18 compare own address
                     if (sh_q[7:1] != `ISP_SLAVE_ADDR) begin
                        st_q <= DS_IGN;
                        oe_q <= 1'b0;
                     end
                  end else if (bidx_q == 2'h1) begin
                     ptr_q <= sh_q;
                  end
               end
            end
            DS_TX: begin
               if (scl_fall && !ack_q) begin
                  // R5 change data only while clock low
                  if (bit_q == `ISP_BITS - 4'h1) begin
                     oe_q <= 1'b0;
                     ack_q <= 1'b1;
                     bit_q <= 4'h0;
                  end else begin
                     oe_q <= ~sh_q[7];
                     sh_q <= sh_q << 1;
                     bit_q <= bit_q + 4'h1;
                  end
               end else if (scl_rise && ack_q) begin
                  nack_q <= sda_s[1];
               end else if (scl_fall && ack_q) begin
                  ack_q <= 1'b0;
                  // R13 nack from master ends sending
                  if (nack_q) begin
                     st_q <= DS_IGN;
                  end else begin
                     sh_q <= {rdat[6:0], 1'b0};
                     oe_q <= ~rdat[7];
                  end
               end
            end
            default: oe_q <= 1'b0;
         endcase
      end
   end

   always_comb begin
      case (ptr_q)
         // R17 live status
         `ISP_R_TH_ST: rdat = 8'(thermal);
         `ISP_R_BF_ST: rdat = 8'(buck_fault);
         `ISP_R_PL_ST: rdat = 8'(pin_level);
         `ISP_R_TH_EV: rdat = 8'(ev_q[`ISP_EV_TH]);
         `ISP_R_BF_EV: rdat = 8'(ev_q[`ISP_EV_BF]);
         `ISP_R_PL_EV: rdat = 8'(ev_q[`ISP_EV_PL]);
         `ISP_R_PART: rdat = PART_ID;
         `ISP_R_REV: rdat = REV_ID;
         `ISP_R_CUST: rdat = CUST_ID;
         `ISP_R_CFGREV: rdat = CFG_REV;
         // R19 undefined and reserved read zero
         default: rdat = rw_q[ptr_q[`ISP_MAP_AW-1:0]] & wmask(ptr_q);
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < (1 << `ISP_MAP_AW); i++) begin
            rw_q[i] <= 8'h00;
         end
      end else if (wr_stb) begin
         // R19 reserved bits keep their value
         rw_q[ptr_q[`ISP_MAP_AW-1:0]] <= (rw_q[ptr_q[`ISP_MAP_AW-1:0]] & ~wmask(ptr_q)) |
            (sh_q & wmask(ptr_q));
      end
   end

   assign src = {pin_level, buck_fault, thermal};
   assign clr = {(wr_stb && ptr_q == `ISP_R_PL_EV) ? sh_q[`ISP_PL_W-1:0] : 3'h0,
                 (wr_stb && ptr_q == `ISP_R_BF_EV) ? sh_q[`ISP_BF_W-1:0] : 4'h0,
                 (wr_stb && ptr_q == `ISP_R_TH_EV) ? sh_q[`ISP_TH_W-1:0] : 2'h0};
   assign msk = {rw_q[6'(`ISP_R_PL_MSK)][`ISP_PL_W-1:0],
                 rw_q[6'(`ISP_R_BF_MSK)][`ISP_BF_W-1:0],
                 rw_q[6'(`ISP_R_TH_MSK)][`ISP_TH_W-1:0]};
   assign lv_msk = rw_q[6'(`ISP_R_LV_MSK)];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         src_q <= '0;
         ev_q <= '0;
      end else begin
         src_q <= src;
         // R16 clear only once source gone, set wins
         ev_q <= (src & ~src_q) | (ev_q & ~(clr & ~src));
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (|(ev_q & ~msk)) | (thermal[`ISP_B_TWARN] & ~lv_msk[`ISP_B_VRHOT]) |
            (buck_fault[`ISP_B_PG1] & ~lv_msk[`ISP_B_PGST]);
      end
   end

   assign irq = irq_q;
   assign buck_current_limit_field = rw_q[6'(`ISP_R_BK_ILIM)][`ISP_F_ILIM];
   assign output_setting_select = rw_q[6'(`ISP_R_BK_MODE)][`ISP_F_VSEL];
   assign setting_one_operating_mode = rw_q[6'(`ISP_R_BK_MODE)][`ISP_F_AMODE];
   assign setting_two_operating_mode = rw_q[6'(`ISP_R_BK_MODE)][`ISP_F_BMODE];
   assign voltage_a = rw_q[6'(`ISP_R_BK_VA)];
   assign voltage_b = rw_q[6'(`ISP_R_BK_VB)];

   // R1 pins follow the enable bit
   // R2 enables only pull low
   assign bus.dev_scl_oe = serial_en ? 1'b0 : gpio_oe[0] & ~gpio_out[0];
   assign bus.dev_sda_oe = serial_en ? oe_q : gpio_oe[1] & ~gpio_out[1];
   assign gpio_in = {sda_s[1], scl_s[1]};
endmodule // isp_device

// ### verilog/isp_defines.svh
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH
// bus timing
`define ISP_SYS_NS 4
`define ISP_SM_NS 10000
`define ISP_FM_NS 2500
`define ISP_FMP_NS 1000
// quarter of a bus period in system clocks, rounded up
`define ISP_QTR(p) (((p) + 4 * `ISP_SYS_NS - 1) / (4 * `ISP_SYS_NS))
`define ISP_SPD_SM 2'h0
`define ISP_SPD_FM 2'h1
`define ISP_Q0 2'h0
`define ISP_Q1 2'h1
`define ISP_Q2 2'h2
`define ISP_Q3 2'h3
`define ISP_SLAVE_ADDR 7'h68
`define ISP_BITS 4'h8
`define ISP_MAP_AW 6
// device register offsets
`define ISP_R_TH_ST 8'h01
`define ISP_R_BF_ST 8'h02
`define ISP_R_PL_ST 8'h03
`define ISP_R_TH_EV 8'h04
`define ISP_R_BF_EV 8'h05
`define ISP_R_PL_EV 8'h06
`define ISP_R_TH_MSK 8'h07
`define ISP_R_BF_MSK 8'h08
`define ISP_R_PL_MSK 8'h09
`define ISP_R_LV_MSK 8'h0a
`define ISP_R_FLT 8'h0d
`define ISP_R_OSC 8'h0e
`define ISP_R_P0_FN 8'h10
`define ISP_R_P0_IN 8'h11
`define ISP_R_P1_FN 8'h12
`define ISP_R_P1_IN 8'h13
`define ISP_R_P2_FN 8'h14
`define ISP_R_P2_IN 8'h15
`define ISP_R_BK_EN 8'h20
`define ISP_R_BK_RAMP 8'h21
`define ISP_R_BK_ILIM 8'h22
`define ISP_R_BK_VMAX 8'h23
`define ISP_R_BK_MODE 8'h24
`define ISP_R_BK_VA 8'h25
`define ISP_R_BK_VB 8'h26
`define ISP_R_PART 8'h48
`define ISP_R_REV 8'h49
`define ISP_R_CUST 8'h4a
`define ISP_R_CFGREV 8'h4b
// writable bits per register
`define ISP_WM_TH 8'h03
`define ISP_WM_BF 8'h0f
`define ISP_WM_PL 8'h07
`define ISP_WM_LV 8'h09
`define ISP_WM_FLT 8'h7c
`define ISP_WM_OSC 8'h72
`define ISP_WM_FN 8'h1f
`define ISP_WM_FULL 8'hff
`define ISP_WM_BK7 8'h7f
`define ISP_WM_ILIM 8'h0f
`define ISP_WM_MODE 8'h1f
// event vector layout and fields
`define ISP_TH_W 2
`define ISP_BF_W 4
`define ISP_PL_W 3
`define ISP_EV_W 9
`define ISP_EV_TH 1:0
`define ISP_EV_BF 5:2
`define ISP_EV_PL 8:6
`define ISP_F_ILIM 3:0
`define ISP_F_VSEL 4
`define ISP_F_AMODE 1:0
`define ISP_F_BMODE 3:2
`define ISP_B_TWARN 0
`define ISP_B_PG1 3
`define ISP_B_VRHOT 3
`define ISP_B_PGST 0
// host registers, byte addresses
`define ISP_H_CMD 5'h00
`define ISP_H_STAT 5'h04
`define ISP_H_IST 5'h08
`define ISP_H_ICLR 5'h0c
`define ISP_H_IEN 5'h10
`define ISP_C_REG 7:0
`define ISP_C_WD 15:8
`define ISP_C_RD 16
`define ISP_C_SPD 18:17
`define ISP_C_ALT 19
`define ISP_S_BUSY 0
`define ISP_S_NACK 1
`define ISP_S_RD 15:8
`define ISP_I_W 2
`endif

// ### verilog/isp_pkg.sv
package isp_pkg;
   typedef enum logic [1:0] {DS_IDLE, DS_RX, DS_TX, DS_IGN} isp_dev_st_t;
   typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} isp_host_st_t;
   typedef logic [9:0] isp_qcnt_t;
endpackage

// ### verilog/isp_if.sv
interface isp_if;
   logic host_scl_oe;
   logic host_sda_oe;
   logic dev_scl_oe;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // open-drain wires with pull-up
   assign scl = ~(host_scl_oe | dev_scl_oe);
   assign sda = ~(host_sda_oe | dev_sda_oe);
   modport dev (input scl, input sda, output dev_scl_oe, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface

// ### verilog/isp_host.sv
`include "isp_defines.svh"
module isp_host import isp_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // serial bus
   isp_if.host bus,
   // register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt
   output logic irq
);
   logic [1:0] sda_s;
   isp_host_st_t st_q;
   isp_qcnt_t cnt_q;
   logic tick;
   logic [1:0] q_q;
   logic [3:0] bit_q;
   logic [2:0] seq_q;
   logic [7:0] sh_q;
   logic tx_q;
   logic scl_oe_q;
   logic sda_oe_q;
   logic nack_q;
   logic [7:0] rdata_q;
   logic [7:0] reg_q;
   logic [7:0] wd_q;
   logic rd_q;
   logic [1:0] spd_q;
   logic alt_q;
   logic accept;
   logic rack_q;
   logic [`ISP_I_W-1:0] ist_q;
   logic [`ISP_I_W-1:0] ien_q;
   logic done_ev;
   logic [31:0] rdv;

   function automatic isp_qcnt_t qcount(input logic [1:0] spd);
      case (spd)
         `ISP_SPD_SM: qcount = 10'(`ISP_QTR(`ISP_SM_NS));
         `ISP_SPD_FM: qcount = 10'(`ISP_QTR(`ISP_FM_NS));
         default: qcount = 10'(`ISP_QTR(`ISP_FMP_NS));
      endcase
   endfunction

   assign accept = avs_write & (avs_address == `ISP_H_CMD) & (st_q == HS_IDLE);
   assign avs_waitrequest = (avs_read & ~rack_q) |
      (avs_write & (avs_address == `ISP_H_CMD) & (st_q != HS_IDLE));
   assign tick = (st_q != HS_IDLE) & (cnt_q == 10'h000);
   assign done_ev = tick & (st_q == HS_STOP) & (q_q == `ISP_Q3);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sda_s <= 2'h3;
      end else begin
         sda_s <= {sda_s[0], bus.sda};
      end
   end

   // R3 quarter-period divider per speed
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 10'h000;
      end else if (st_q == HS_IDLE || cnt_q == 10'h000) begin
         cnt_q <= (st_q == HS_IDLE) ? 10'h000 : qcount(spd_q) - 10'h001;
      end else begin
         cnt_q <= cnt_q - 10'h001;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= HS_IDLE;
         {q_q, bit_q, seq_q, sh_q, tx_q, scl_oe_q, sda_oe_q, nack_q} <= '0;
         {rdata_q, reg_q, wd_q, rd_q, spd_q, alt_q} <= '0;
      end else if (accept) begin
         st_q <= HS_START;
         q_q <= `ISP_Q0;
         seq_q <= 3'h0;
         nack_q <= 1'b0;
         reg_q <= avs_writedata[`ISP_C_REG];
         wd_q <= avs_writedata[`ISP_C_WD];
         rd_q <= avs_writedata[`ISP_C_RD];
         spd_q <= avs_writedata[`ISP_C_SPD];
         alt_q <= avs_writedata[`ISP_C_ALT];
      end else if (tick) begin
         q_q <= q_q + 2'h1;
         case (st_q)
            // R6 start, also repeated start
            HS_START: begin
               case (q_q)
                  `ISP_Q0: sda_oe_q <= 1'b0;
                  `ISP_Q1: scl_oe_q <= 1'b0;
                  `ISP_Q2: sda_oe_q <= 1'b1;
                  default: begin
                     scl_oe_q <= 1'b1;
                     st_q <= HS_BYTE;
                     bit_q <= 4'h0;
                     tx_q <= 1'b1;
                     // alternate address lets software reach a foreign slave
                     sh_q <= {`ISP_SLAVE_ADDR ^ 7'(alt_q), seq_q != 3'h0};
                  end
               endcase
            end
            HS_BYTE: begin
               case (q_q)
                  // R5 R13 drive while low, release for nack
                  `ISP_Q0: sda_oe_q <= tx_q & (bit_q < `ISP_BITS) & ~sh_q[7];
                  `ISP_Q1: scl_oe_q <= 1'b0;
                  `ISP_Q2: begin
                     // R4 R9 msb first, ninth bit acknowledge
                     if (bit_q < `ISP_BITS) begin
                        sh_q <= {sh_q[6:0], sda_s[1]};
                     end else begin
                        nack_q <= tx_q & sda_s[1];
                     end
                  end
                  default: begin
                     scl_oe_q <= 1'b1;
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == `ISP_BITS) begin
                        bit_q <= 4'h0;
                        // R10 R12 byte sequence
                        if (nack_q) begin
                           st_q <= HS_STOP;
                        end else begin
                           case (seq_q)
                              3'h0: begin
                                 sh_q <= reg_q;
                                 seq_q <= 3'h1;
                              end
                              3'h1: begin
                                 seq_q <= rd_q ? 3'h3 : 3'h2;
                                 if (rd_q) begin
                                    st_q <= HS_START;
                                 end
                                 sh_q <= wd_q;
                              end
                              3'h3: begin
                                 seq_q <= 3'h4;
                                 tx_q <= 1'b0;
                                 sh_q <= 8'hff;
                              end
                              3'h4: begin
                                 rdata_q <= sh_q;
                                 st_q <= HS_STOP;
                              end
                              default: st_q <= HS_STOP;
                           endcase
                        end
                     end
                  end
               endcase
            end
            // R7 stop
            HS_STOP: begin
               case (q_q)
                  `ISP_Q0: sda_oe_q <= 1'b1;
                  `ISP_Q1: scl_oe_q <= 1'b0;
                  `ISP_Q2: sda_oe_q <= 1'b0;
                  default: st_q <= HS_IDLE;
               endcase
            end
            default: st_q <= HS_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ist_q <= '0;
         ien_q <= '0;
      end else begin
         // set wins over clear
         ist_q <= ({nack_q & done_ev, done_ev}) |
            (ist_q & ~((avs_write && avs_address == `ISP_H_ICLR) ?
            avs_writedata[`ISP_I_W-1:0] : 2'h0));
         if (avs_write && avs_address == `ISP_H_IEN) begin
            ien_q <= avs_writedata[`ISP_I_W-1:0];
         end
      end
   end

   always_comb begin
      rdv = 32'h0;
      case (avs_address)
         `ISP_H_STAT: begin
            rdv[`ISP_S_BUSY] = st_q != HS_IDLE;
            rdv[`ISP_S_NACK] = nack_q;
            rdv[`ISP_S_RD] = rdata_q;
         end
         `ISP_H_IST: rdv = 32'(ist_q);
         `ISP_H_IEN: rdv = 32'(ien_q);
         default: rdv = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rack_q <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         rack_q <= avs_read & ~rack_q;
         if (avs_read && !rack_q) begin
            avs_readdata <= rdv;
         end
      end
   end

   // R2 open-drain enables
   assign bus.host_scl_oe = scl_oe_q;
   assign bus.host_sda_oe = sda_oe_q;
   assign irq = |(ist_q & ien_q);
endmodule // isp_host

// ### bench/isp_sva.sv
`include "isp_defines.svh"
module isp_sva (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // wire enables and levels
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_scl_oe,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q, sda_q, busy_q, nak_q, own_q, rd_q;
   logic [3:0] bit_q;
   logic [1:0] byte_q;
   logic [7:0] sh_q;
   logic rise, start, stop, nine;
   assign rise = scl & ~scl_q;
   assign start = scl & scl_q & sda_q & ~sda;
   assign stop = scl & scl_q & ~sda_q & sda;
   assign nine = rise && bit_q == 4'h8;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         busy_q <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         busy_q <= start | (busy_q & ~stop);
      end
   end
   // bit and byte position since the last start
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         nak_q <= 1'b0;
      end else if (start || stop) begin
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         nak_q <= 1'b0;
      end else if (nine) begin
         bit_q <= 4'h0;
         byte_q <= byte_q + 2'h1;
         nak_q <= nak_q | (byte_q == 2'h0 && sda);
      end else if (rise) begin
         bit_q <= bit_q + 4'h1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rise) sh_q <= {sh_q[6:0], sda};
      if (nine && byte_q == 2'h0) begin
         own_q <= sh_q[7:1] == `ISP_SLAVE_ADDR;
         rd_q <= sh_q[0];
      end
   end
   a_no_stretch: assert property (busy_q |-> !dev_scl_oe)
      else $error("device pulled clock during transfer");
   a_host_release: assert property (nine |-> !host_sda_oe)
      else $error("host drove data in acknowledge clock");
   a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device moved data with clock high");
   a_ack_held: assert property ($rose(scl) && dev_sda_oe |=> dev_sda_oe [*8])
      else $error("device data dropped in clock high");
   a_idle_quiet: assert property (!busy_q && scl |-> !dev_sda_oe)
      else $error("device drove idle bus");
   a_write_ack: assert property (nine && byte_q != 2'h0 && own_q && !rd_q && !nak_q |-> dev_sda_oe)
      else $error("write byte not acknowledged");
   a_read_release: assert property (nine && byte_q == 2'h1 && own_q && rd_q |-> !dev_sda_oe)
      else $error("device held data in master ack");
   a_foreign_quiet: assert property (nak_q |-> !dev_sda_oe)
      else $error("device drove after address nack");
endmodule // isp_sva

// ### bench/test_i2c_register_slave_port.sv
`include "isp_defines.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module test_i2c_register_slave_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, serial_en, h_irq, d_irq, vsel;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdv;
   logic [1:0] gpio_out, gpio_oe, gpio_in, thermal, mode_a, mode_b;
   logic [3:0] buck_fault, ilim;
   logic [2:0] pin_level;
   logic [7:0] volt_a, volt_b;
   int failures = 0;
   int check_count = 0;
   logic alt_addr = 1'b0;
   isp_if u_isp_if ();
   isp_host u_isp_host (.sys_clk, .rst, .bus(u_isp_if.host), .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq(h_irq));
   isp_device #(.PART_ID(8'h5a)) u_isp_device (.sys_clk, .rst, .bus(u_isp_if.dev), .serial_en,
      .gpio_out,
      .gpio_oe, .gpio_in, .thermal, .buck_fault, .pin_level, .irq(d_irq),
      .buck_current_limit_field(ilim), .output_setting_select(vsel),
      .setting_one_operating_mode(mode_a), .setting_two_operating_mode(mode_b),
      .voltage_a(volt_a), .voltage_b(volt_b));
   isp_sva u_isp_sva (.sys_clk, .rst, .host_scl_oe(u_isp_if.host_scl_oe),
      .host_sda_oe(u_isp_if.host_sda_oe), .dev_scl_oe(u_isp_if.dev_scl_oe),
      .dev_sda_oe(u_isp_if.dev_sda_oe), .scl(u_isp_if.scl), .sda(u_isp_if.sda));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20000);
      rdv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20000) begin
         $display("MISMATCH %0t bus wait timeout", $time);
         failures++;
         finish_test;
      end
   endtask
   // one bus command, then poll until idle
   task automatic cmd(input logic [7:0] r, input logic [7:0] d, input logic rnw,
      input logic [1:0] s);
      int n;
      av(`ISP_H_CMD, 1'b1, {12'h0, alt_addr, s, rnw, d, r});
      n = 0;
      do begin
         av(`ISP_H_STAT, 1'b0, 32'h0);
         n++;
      end while (rdv[`ISP_S_BUSY] !== 1'b0 && n < 20000);
      if (n >= 20000) begin
         $display("MISMATCH %0t busy timeout", $time);
         failures++;
         finish_test;
      end
   endtask
   task automatic dr(input logic [7:0] r, input logic [7:0] e);
      cmd(r, 8'h00, 1'b1, 2'h2);
      `CHK(rdv[`ISP_S_NACK], 1'b0)
      `CHK(rdv[`ISP_S_RD], e)
   endtask
   task automatic t_regs;
      cmd(`ISP_R_BK_ILIM, 8'hff, 1'b0, 2'h2);
      dr(`ISP_R_BK_ILIM, 8'h0f);
      `CHK(ilim, 4'hf)
      cmd(`ISP_R_BK_MODE, 8'hfe, 1'b0, 2'h2);
      dr(`ISP_R_BK_MODE, 8'h1e);
      `CHK({vsel, mode_b, mode_a}, 5'h1e)
      cmd(`ISP_R_BK_VB, 8'h35, 1'b0, 2'h1);
      dr(`ISP_R_BK_VB, 8'h35);
      `CHK(volt_b, 8'h35)
      cmd(8'h0b, 8'hff, 1'b0, 2'h2);
      dr(8'h0b, 8'h00);
      dr(8'h30, 8'h00);
      dr(`ISP_R_PART, 8'h5a);
      $display("t_regs done");
   endtask
   task automatic t_events;
      thermal <= 2'h1;
      repeat (4) @(posedge sys_clk);
      `CHK(d_irq, 1'b1)
      dr(`ISP_R_TH_ST, 8'h01);
      cmd(`ISP_R_TH_EV, 8'h01, 1'b0, 2'h2);
      dr(`ISP_R_TH_EV, 8'h01);
      thermal <= 2'h0;
      dr(`ISP_R_TH_ST, 8'h00);
      cmd(`ISP_R_TH_EV, 8'h01, 1'b0, 2'h2);
      dr(`ISP_R_TH_EV, 8'h00);
      `CHK(d_irq, 1'b0)
      $display("t_events done");
   endtask
   task automatic t_disabled;
      serial_en <= 1'b0;
      av(`ISP_H_IEN, 1'b1, 32'h2);
      cmd(`ISP_R_TH_ST, 8'h00, 1'b1, 2'h2);
      `CHK(rdv[`ISP_S_NACK], 1'b1)
      `CHK(h_irq, 1'b1)
      av(`ISP_H_IEN, 1'b1, 32'h0);
      av(`ISP_H_IST, 1'b0, 32'h0);
      `CHK({rdv[1], h_irq}, 2'b10)
      av(`ISP_H_ICLR, 1'b1, 32'h3);
      av(`ISP_H_IST, 1'b0, 32'h0);
      `CHK(rdv[1:0], 2'b00)
      av(5'h1c, 1'b0, 32'h0);
      `CHK(rdv, 32'h0)
      gpio_oe <= 2'b01;
      repeat (4) @(posedge sys_clk);
      `CHK(gpio_in, 2'b10)
      gpio_oe <= 2'b11;
      repeat (4) @(posedge sys_clk);
      `CHK(gpio_in, 2'b00)
      gpio_out <= 2'b10;
      repeat (4) @(posedge sys_clk);
      `CHK(gpio_in, 2'b10)
      gpio_oe <= 2'b01;
      repeat (4) @(posedge sys_clk);
      gpio_oe <= 2'b00;
      repeat (4) @(posedge sys_clk);
      serial_en <= 1'b1;
      alt_addr = 1'b1;
      cmd(`ISP_R_TH_ST, 8'h00, 1'b1, 2'h1);
      alt_addr = 1'b0;
      `CHK(rdv[`ISP_S_NACK], 1'b1)
      $display("t_disabled done");
   endtask
   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      serial_en = 1'b1;
      gpio_out = 2'h0;
      gpio_oe = 2'h0;
      thermal = 2'h0;
      buck_fault = 4'h0;
      pin_level = 3'h0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t_regs;
      t_events;
      t_disabled;
      finish_test;
   end
endmodule // test_i2c_register_slave_port
